//--- include/atg_pkg.sv
// Constants, register map and carrier types for the axis travel limit guard.
`default_nettype none
package atg_pkg;
	localparam int ATG_AXES = 3;
	localparam int ATG_BOUNDS = 12;
	localparam int ATG_EVENTS = 14;
	localparam int ATG_ADDR_W = 12;
	localparam logic [11:0] ATG_ADDR_CTRL = 12'h000;
	localparam logic [11:0] ATG_ADDR_STATUS = 12'h004;
	localparam logic [11:0] ATG_ADDR_IRQ_STAT = 12'h008;
	localparam logic [11:0] ATG_ADDR_IRQ_MASK = 12'h00C;
	// Bound registers start here, one word each; axis order is z, x, y with the positive bound first.
	localparam logic [11:0] ATG_ADDR_BOUND_BASE = 12'h010;
	localparam logic [3:0] ATG_BOUND_FIRST_WORD = 4'h4;
	localparam int ATG_TIP_BASE = 0;
	localparam int ATG_MECH_BASE = 6;
	localparam logic [4:0] ATG_CTRL_RESET = 5'h06;
	localparam logic [31:0] ATG_BOUND_POS_RESET = 32'h7FFFFFFF;
	localparam logic [31:0] ATG_BOUND_NEG_RESET = 32'h80000000;
	localparam logic [13:0] ATG_MASK_RESET = 14'h0000;
	localparam int ATG_CLK_MHZ = 100;
	localparam int ATG_FILTER_NS = 1000;
	localparam int ATG_FILTER_CYCLES = (ATG_FILTER_NS * ATG_CLK_MHZ + 999) / 1000;
	localparam logic [1:0] ATG_RESP_OKAY = 2'h0;
	localparam logic [1:0] ATG_RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic tip_en;
		logic mech_en;
		logic polarity;
		logic detect_en;
		logic mode;
	} atg_ctrl_t;
	typedef struct packed {
		logic [2:0] tip_neg;
		logic [2:0] tip_pos;
		logic [2:0] mech_neg;
		logic [2:0] mech_pos;
		logic hard_neg;
		logic hard_pos;
	} atg_alarm_t;
endpackage
`default_nettype wire

//--- rtl/atg_guard.sv
// Travel limit guard: hard limit switches, soft limit bounds, alarms, feed control and AXI4-Lite registers.
//
// What this block does
// - Active hard limit stops all feed, halts the program, raises hard alarm.
// - Hard alarm clears in manual mode once the carriage leaves the switch.
// - One shared positive limit input and one shared negative limit input.
// - Positive hard alarm blocks positive motion on all axes; negative likewise.
// - Mode bit set makes a hard limit hit an emergency-stop style halt.
// - Detection enable bit off means no hard limit alarms are raised.
// - Polarity one: high level on a limit input is the alarm condition.
// - Polarity zero: low level on a limit input is the alarm condition.
// - Machine position beyond its mechanical bound raises mechanical soft alarm.
// - Tool-tip position beyond its tool-tip bound raises tool-tip soft alarm.
// - Soft alarm clears on manual move opposite the overtravel, back in range.
// - Crossing a soft bound brings the axes to a decelerated stop.
// - Separate positive and negative bounds per axis, mechanical and tool-tip sets.
// - Independent enables for mechanical and tool-tip checks; disabled raises nothing.
`timescale 1ns/1ps
`default_nettype none
module atg_guard
	import atg_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic shared_positive_limit_in,
	input wire logic shared_negative_limit_in,
	input wire logic manual_mode,
	input wire logic [2:0] jog_pos,
	input wire logic [2:0] jog_neg,
	input wire logic [2:0][31:0] machine_pos,
	input wire logic [2:0][31:0] tooltip_pos,
	output logic feed_stop,
	output logic feed_decel,
	output logic program_halt,
	output logic estop_halt,
	output logic [2:0] block_pos,
	output logic [2:0] block_neg,
	output logic irq
);
	atg_ctrl_t ctrl;
	atg_alarm_t alarm;
	atg_alarm_t alarm_q;
	logic [13:0] irq_stat;
	logic [13:0] irq_mask;
	logic [31:0] bound [ATG_BOUNDS];
	logic [1:0] sync_a;
	logic [1:0] sync_b;
	logic [1:0] filt_level;
	logic [1:0][7:0] filt_cnt;
	logic [1:0] limit_active;
	logic [2:0] mech_pos_v;
	logic [2:0] mech_neg_v;
	logic [2:0] tip_pos_v;
	logic [2:0] tip_neg_v;
	atg_alarm_t next_alarm;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	// Filter: the clean level follows the synchronised input only after it stood for the whole filter time.
	genvar gl;
	generate
		for (gl = 0; gl < 2; gl++)
		begin : g_limit
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					filt_cnt[gl] <= 8'h00;
					filt_level[gl] <= 1'b0;
				end
				else if (sync_b[gl] == filt_level[gl])
					filt_cnt[gl] <= 8'h00;
				else if (filt_cnt[gl] == 8'(ATG_FILTER_CYCLES - 1))
				begin
					filt_cnt[gl] <= 8'h00;
					filt_level[gl] <= sync_b[gl];
				end
				else
					filt_cnt[gl] <= filt_cnt[gl] + 8'h01;
			end
			assign limit_active[gl] = ctrl.polarity ? filt_level[gl] : ~filt_level[gl];
		end
	endgenerate

	// Two stages per shared switch line; only the second stage is looked at.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync_a <= 2'h0;
			sync_b <= 2'h0;
		end
		else
		begin
			sync_a <= {shared_negative_limit_in, shared_positive_limit_in};
			sync_b <= sync_a;
		end
	end

	// Hard alarms hold until manual mode and the switch released; the release is only reachable by reverse travel.
	assign next_alarm.hard_pos = ctrl.detect_en & (limit_active[0] | (alarm.hard_pos & ~manual_mode));
	assign next_alarm.hard_neg = ctrl.detect_en & (limit_active[1] | (alarm.hard_neg & ~manual_mode));

	genvar ga;
	generate
		for (ga = 0; ga < ATG_AXES; ga++)
		begin : g_axis
			assign mech_pos_v[ga] = $signed(machine_pos[ga]) > $signed(bound[ATG_MECH_BASE + 2 * ga]);
			assign mech_neg_v[ga] = $signed(machine_pos[ga]) < $signed(bound[ATG_MECH_BASE + 2 * ga + 1]);
			assign tip_pos_v[ga] = $signed(tooltip_pos[ga]) > $signed(bound[ATG_TIP_BASE + 2 * ga]);
			assign tip_neg_v[ga] = $signed(tooltip_pos[ga]) < $signed(bound[ATG_TIP_BASE + 2 * ga + 1]);
			// A new violation wins over the clear, so an axis never slips out of alarm while still outside.
			assign next_alarm.mech_pos[ga] = ctrl.mech_en & (mech_pos_v[ga]
				| (alarm.mech_pos[ga] & ~(manual_mode & jog_neg[ga])));
			assign next_alarm.mech_neg[ga] = ctrl.mech_en & (mech_neg_v[ga]
				| (alarm.mech_neg[ga] & ~(manual_mode & jog_pos[ga])));
			assign next_alarm.tip_pos[ga] = ctrl.tip_en & (tip_pos_v[ga]
				| (alarm.tip_pos[ga] & ~(manual_mode & jog_neg[ga])));
			assign next_alarm.tip_neg[ga] = ctrl.tip_en & (tip_neg_v[ga]
				| (alarm.tip_neg[ga] & ~(manual_mode & jog_pos[ga])));
			assign block_pos[ga] = alarm.hard_pos | alarm.mech_pos[ga] | alarm.tip_pos[ga];
			assign block_neg[ga] = alarm.hard_neg | alarm.mech_neg[ga] | alarm.tip_neg[ga];
		end
	endgenerate

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			alarm <= '0;
			alarm_q <= '0;
		end
		else
		begin
			alarm <= next_alarm;
			alarm_q <= alarm;
		end
	end

	// Hard hits halt at once; soft hits decelerate because the position is known and no coordinates are lost.
	assign feed_stop = alarm.hard_pos | alarm.hard_neg;
	assign estop_halt = feed_stop & ctrl.mode;
	assign feed_decel = |{alarm.mech_pos, alarm.mech_neg, alarm.tip_pos, alarm.tip_neg};
	assign program_halt = feed_stop | feed_decel;
	assign irq = |(irq_stat & irq_mask);

	// Register slave: a write needs address and data together, the response comes one cycle later.
	logic wr_go;
	logic rd_go;
	logic w_bound_hit;
	logic r_bound_hit;
	logic [3:0] w_bidx;
	logic [3:0] r_bidx;
	logic [31:0] wmask;
	logic w_known;
	assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign rd_go = s_axi_arvalid & ~s_axi_rvalid;
	assign s_axi_arready = rd_go;
	assign w_bound_hit = (s_axi_awaddr[11:6] == 6'h00) && (s_axi_awaddr[5:4] != 2'h0);
	assign r_bound_hit = (s_axi_araddr[11:6] == 6'h00) && (s_axi_araddr[5:4] != 2'h0);
	assign w_bidx = s_axi_awaddr[5:2] - ATG_BOUND_FIRST_WORD;
	assign r_bidx = s_axi_araddr[5:2] - ATG_BOUND_FIRST_WORD;
	assign w_known = w_bound_hit || s_axi_awaddr == ATG_ADDR_CTRL || s_axi_awaddr == ATG_ADDR_STATUS
		|| s_axi_awaddr == ATG_ADDR_IRQ_STAT || s_axi_awaddr == ATG_ADDR_IRQ_MASK;

	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++)
		begin : g_strb
			assign wmask[8 * gb +: 8] = {8{s_axi_wstrb[gb]}};
		end
		for (gb = 0; gb < ATG_BOUNDS; gb++)
		begin : g_bound
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					bound[gb] <= (gb % 2 == 0) ? ATG_BOUND_POS_RESET : ATG_BOUND_NEG_RESET;
				else if (wr_go && w_bound_hit && w_bidx == 4'(gb))
					bound[gb] <= (bound[gb] & ~wmask) | (s_axi_wdata & wmask);
			end
		end
	endgenerate

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl <= ATG_CTRL_RESET;
			irq_mask <= ATG_MASK_RESET;
			irq_stat <= '0;
		end
		else
		begin
			if (wr_go && s_axi_awaddr == ATG_ADDR_CTRL && s_axi_wstrb[0])
				ctrl <= s_axi_wdata[4:0];
			if (wr_go && s_axi_awaddr == ATG_ADDR_IRQ_MASK)
				irq_mask <= (irq_mask & ~wmask[13:0]) | (s_axi_wdata[13:0] & wmask[13:0]);
			// A fresh alarm edge in the same cycle as a write-one-to-clear keeps its bit.
			if (wr_go && s_axi_awaddr == ATG_ADDR_IRQ_STAT)
				irq_stat <= (irq_stat & ~(s_axi_wdata[13:0] & wmask[13:0])) | (alarm & ~alarm_q);
			else
				irq_stat <= irq_stat | (alarm & ~alarm_q);
		end
	end

	always_comb
	begin
		next_rdata = 32'h00000000;
		next_rresp = ATG_RESP_OKAY;
		if (r_bound_hit)
			next_rdata = bound[r_bidx];
		else
		begin
			case (s_axi_araddr)
				ATG_ADDR_CTRL: next_rdata = {27'h0000000, ctrl};
				ATG_ADDR_STATUS: next_rdata = {18'h00000, alarm};
				ATG_ADDR_IRQ_STAT: next_rdata = {18'h00000, irq_stat};
				ATG_ADDR_IRQ_MASK: next_rdata = {18'h00000, irq_mask};
				default: next_rresp = ATG_RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ATG_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= ATG_RESP_OKAY;
		end
		else
		begin
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= w_known ? ATG_RESP_OKAY : ATG_RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (rd_go)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= next_rdata;
				s_axi_rresp <= next_rresp;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_hard_stop;
		alarm.hard_pos || alarm.hard_neg |-> feed_stop && program_halt;
	endproperty
	a_hard_stop: assert property (p_hard_stop) else $error("hard alarm without feed stop");

	property p_hard_clear;
		alarm.hard_pos && manual_mode && !limit_active[0] |=> !alarm.hard_pos;
	endproperty
	a_hard_clear: assert property (p_hard_clear) else $error("hard alarm not cleared after leaving switch");

	property p_pos_block;
		alarm.hard_pos |-> block_pos == 3'h7;
	endproperty
	a_pos_block: assert property (p_pos_block) else $error("positive motion not blocked");

	property p_neg_block;
		alarm.hard_neg |-> block_neg == 3'h7;
	endproperty
	a_neg_block: assert property (p_neg_block) else $error("negative motion not blocked");

	property p_mode;
		feed_stop |-> estop_halt == ctrl.mode;
	endproperty
	a_mode: assert property (p_mode) else $error("halt style does not follow mode bit");

	property p_detect_off;
		!ctrl.detect_en ##1 !ctrl.detect_en |-> !alarm.hard_pos && !alarm.hard_neg;
	endproperty
	a_detect_off: assert property (p_detect_off) else $error("hard alarm while detection off");

	property p_pol_high;
		$rose(alarm.hard_pos) && $past(ctrl.polarity) && $past(ctrl.detect_en) |-> $past(filt_level[0]);
	endproperty
	a_pol_high: assert property (p_pol_high) else $error("alarm on low level with polarity one");

	property p_pol_low;
		$rose(alarm.hard_pos) && !$past(ctrl.polarity) && $past(ctrl.detect_en) |-> !$past(filt_level[0]);
	endproperty
	a_pol_low: assert property (p_pol_low) else $error("alarm on high level with polarity zero");

	property p_mech;
		ctrl.mech_en && mech_pos_v[1] |=> alarm.mech_pos[1] || !$past(ctrl.mech_en);
	endproperty
	a_mech: assert property (p_mech) else $error("mechanical overtravel not flagged");

	property p_tip;
		ctrl.tip_en && tip_neg_v[0] |=> alarm.tip_neg[0] || !$past(ctrl.tip_en);
	endproperty
	a_tip: assert property (p_tip) else $error("tool-tip overtravel not flagged");

	property p_soft_clear;
		alarm.mech_pos[1] && manual_mode && jog_neg[1] && !mech_pos_v[1] |=> !alarm.mech_pos[1];
	endproperty
	a_soft_clear: assert property (p_soft_clear) else $error("soft alarm held after reverse move");

	property p_decel;
		(|alarm[13:2]) |-> feed_decel && program_halt;
	endproperty
	a_decel: assert property (p_decel) else $error("soft alarm without deceleration");

	property p_mech_off;
		!ctrl.mech_en |=> alarm.mech_pos == 3'h0 && alarm.mech_neg == 3'h0;
	endproperty
	a_mech_off: assert property (p_mech_off) else $error("mechanical alarm while check disabled");

	property p_filter;
		$changed(filt_level[0]) |-> $past(sync_b[0]) == filt_level[0]
			&& $past(filt_cnt[0]) == 8'(ATG_FILTER_CYCLES - 1);
	endproperty
	a_filter: assert property (p_filter) else $error("limit level changed before filter time");
endmodule
`default_nettype wire

//--- tb/atg_switches.sv
// Behavioural model of the shared limit switch strings that feed the travel limit guard.
`timescale 1ns/1ps
`default_nettype none
module atg_switches
(
	input wire logic polarity,
	input wire logic hit_pos,
	input wire logic hit_neg,
	output logic lim_pos,
	output logic lim_neg
);
	// A series string of closed contacts opens on a hit; a parallel string of open contacts closes on a hit.
	assign lim_pos = hit_pos ? polarity : ~polarity;
	assign lim_neg = hit_neg ? polarity : ~polarity;
endmodule
`default_nettype wire

//--- tb/axis_travel_limit_guard_tb.sv
// Self-checking bench for the travel limit guard, driving its register bus, switches and positions.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module axis_travel_limit_guard_tb
	import atg_pkg::*;
;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pol, hp, hn, man;
	logic awready, wready, bvalid, arready, rvalid, lp, ln, fs, fd, ph, eh, irq;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [2:0] jp, jn, bp, bn;
	logic [2:0][31:0] mp, tp;
	int err_count, tests_run;
	atg_switches i_atg_switches (.polarity(pol), .hit_pos(hp), .hit_neg(hn), .lim_pos(lp), .lim_neg(ln));
	atg_guard i_atg_guard (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .shared_positive_limit_in(lp),
		.shared_negative_limit_in(ln), .manual_mode(man), .jog_pos(jp), .jog_neg(jn), .machine_pos(mp),
		.tooltip_pos(tp), .feed_stop(fs), .feed_decel(fd), .program_halt(ph), .estop_halt(eh),
		.block_pos(bp), .block_neg(bn), .irq(irq));
	always #5 aclk = ~aclk;
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Requests are held until the edge where ready is high; ready is looked at 1 ns after each edge.
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = ATG_RESP_OKAY);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		#1;
		while (!(awready && wready)) @(posedge aclk) #1;
		@(posedge aclk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		#1;
		while (!bvalid) @(posedge aclk) #1;
		`CHK(bresp, r)
		@(posedge aclk);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		#1;
		while (!arready) @(posedge aclk) #1;
		@(posedge aclk);
		arvalid <= 1'b0;
		#1;
		while (!rvalid) @(posedge aclk) #1;
		`CHK({rdata, rresp}, {d, r})
		@(posedge aclk);
		rready <= 1'b0;
	endtask
	task automatic drv(input logic p, input logic n, input logic m);
		@(posedge aclk);
		hp <= p;
		hn <= n;
		man <= m;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	initial
	begin
		repeat (20000) @(posedge aclk);
		err_count++;
		summarize();
	end
	initial
	begin
		aclk = 1'b0;
		aresetn = 1'b0;
		pol = 1'b1;
		wstrb = 4'hF;
		err_count = 0;
		tests_run = 0;
		{awvalid, wvalid, bready, arvalid, rready, hp, hn, man} = '0;
		{awaddr, araddr, wdata, jp, jn, mp, tp} = '0;
		cyc(6);
		aresetn <= 1'b1;
		rd(ATG_ADDR_CTRL, 32'h00000006, ATG_RESP_OKAY);
		rd(12'h010, ATG_BOUND_POS_RESET, ATG_RESP_OKAY);
		rd(12'h03C, ATG_BOUND_NEG_RESET, ATG_RESP_OKAY);
		rd(12'h040, 32'h00000000, ATG_RESP_SLVERR);
		wr(ATG_ADDR_IRQ_MASK, 32'h00003FFF);
		// A hit shorter than the filter span must be swallowed.
		drv(1'b1, 1'b0, 1'b0);
		cyc(50);
		drv(1'b0, 1'b0, 1'b0);
		cyc(120);
		#1 `CHK(fs, 1'b0)
		drv(1'b1, 1'b0, 1'b0);
		cyc(110);
		#1 `CHK({fs, ph, eh, bp, bn}, 9'h1B8)
		`CHK(irq, 1'b1)
		rd(ATG_ADDR_STATUS, 32'h00000001, ATG_RESP_OKAY);
		drv(1'b1, 1'b0, 1'b1);
		cyc(5);
		#1 `CHK(fs, 1'b1)
		drv(1'b0, 1'b0, 1'b1);
		cyc(110);
		#1 `CHK({fs, bp}, 4'h0)
		wr(ATG_ADDR_IRQ_STAT, 32'h00000001);
		#1 `CHK(irq, 1'b0)
		wr(ATG_ADDR_CTRL, 32'h00000007);
		drv(1'b0, 1'b1, 1'b0);
		cyc(110);
		#1 `CHK({fs, ph, eh, bp, bn}, 9'h1C7)
		drv(1'b0, 1'b0, 1'b1);
		cyc(110);
		#1 `CHK(fs, 1'b0)
		// Low-active strings idle high; the filter needs its span to follow before the check.
		wr(ATG_ADDR_CTRL, 32'h00000002);
		pol <= 1'b0;
		cyc(110);
		#1 `CHK(fs, 1'b0)
		drv(1'b1, 1'b0, 1'b0);
		cyc(110);
		#1 `CHK({fs, bp}, 4'hF)
		drv(1'b0, 1'b0, 1'b1);
		cyc(110);
		wr(ATG_ADDR_CTRL, 32'h00000004);
		pol <= 1'b1;
		drv(1'b1, 1'b0, 1'b0);
		cyc(110);
		#1 `CHK(fs, 1'b0)
		drv(1'b0, 1'b0, 1'b0);
		cyc(110);
		wr(12'h030, 32'h00000064);
		mp[1] <= 32'h00000065;
		cyc(3);
		#1 `CHK(fd, 1'b0)
		wr(ATG_ADDR_CTRL, 32'h0000000C);
		cyc(3);
		#1 `CHK({fs, fd, ph}, 3'h3)
		rd(ATG_ADDR_STATUS, 32'h00000008, ATG_RESP_OKAY);
		@(posedge aclk);
		man <= 1'b1;
		jp <= 3'h2;
		mp[1] <= 32'h00000064;
		cyc(3);
		#1 `CHK(fd, 1'b1)
		@(posedge aclk);
		jp <= 3'h0;
		jn <= 3'h2;
		cyc(3);
		#1 `CHK(fd, 1'b0)
		@(posedge aclk);
		man <= 1'b0;
		jn <= 3'h0;
		wr(12'h014, 32'hFFFFFFCE);
		tp[0] <= 32'hFFFFFFCD;
		wr(ATG_ADDR_CTRL, 32'h00000014);
		cyc(3);
		#1 `CHK(fd, 1'b1)
		rd(ATG_ADDR_STATUS, 32'h00000800, ATG_RESP_OKAY);
		wr(ATG_ADDR_CTRL, 32'h00000004);
		cyc(3);
		#1 `CHK(fd, 1'b0)
		wr(12'h040, 32'h00000000, ATG_RESP_SLVERR);
		// Without byte lane zero the control word must keep its value.
		wstrb <= 4'h0;
		wr(ATG_ADDR_CTRL, 32'h0000001F);
		wstrb <= 4'hF;
		rd(ATG_ADDR_CTRL, 32'h00000004, ATG_RESP_OKAY);
		summarize();
	end
endmodule
`default_nettype wire
